// ===== hw/rcf_pkg.sv
// package: register map, field layout and carriers of the reset cause block
`default_nettype none

package rcf_pkg;

  // ----------------------------------------------------------------
  // register byte offsets on the bus
  // ----------------------------------------------------------------
  localparam logic [7:0] RCF_RCC_OFF = 8'h00;
  localparam logic [7:0] RCF_STS_OFF = 8'h04;
  localparam logic [7:0] RCF_MSK_OFF = 8'h08;
  localparam int unsigned RCF_ADDR_W = 8;

  // ----------------------------------------------------------------
  // reset_cause_control field positions and values
  // ----------------------------------------------------------------
  localparam int unsigned RCF_RCC_W = 8;
  localparam int unsigned RCF_PRIO_BIT = 7;
  localparam int unsigned RCF_SWRST_BIT = 4;
  localparam int unsigned RCF_WDOG_BIT = 3;
  localparam int unsigned RCF_PWRDN_BIT = 2;
  localparam int unsigned RCF_PWRON_BIT = 1;
  localparam int unsigned RCF_BROWN_BIT = 0;
  localparam logic [7:0] RCF_RCC_RESET = 8'h1c;
  localparam logic [7:0] RCF_RCC_WMASK = 8'h9f;

  // ----------------------------------------------------------------
  // event and interrupt layout
  // ----------------------------------------------------------------
  localparam int unsigned RCF_EV_N = 6;
  localparam logic [5:0] RCF_EV_NONE = 6'h00;

  // one bit per event source; sw_reset is bit 0
  typedef struct packed {
    logic brown_out;
    logic power_on;
    logic sleep;
    logic clear_watchdog;
    logic wdt_timeout;
    logic sw_reset;
  } rcf_evt_s;

  // ----------------------------------------------------------------
  // bus encodings and carriers
  // ----------------------------------------------------------------
  localparam int unsigned RCF_HTRANS_ACT_BIT = 1;
  localparam logic RCF_HRESP_OKAY = 1'b0;
  localparam logic [31:0] RCF_RDATA_ZERO = 32'h0000_0000;

  // address phase captured for the data phase
  typedef struct packed {
    logic [7:0] addr;
    logic write;
    logic valid;
  } rcf_aphase_s;

  typedef enum logic [1:0] {
    RCF_BUS_IDLE,
    RCF_BUS_RD_WAIT
  } rcf_bus_e;

endpackage

`default_nettype wire

// ===== hw/rcf_evt_sync.sv
// module: two-flop synchronisers and rising edge pulses for event inputs
`default_nettype none

module rcf_evt_sync #(
  parameter int unsigned N = 6
) (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic [N-1:0] i_level,
  output logic [N-1:0] o_pulse
);

  // ----------------------------------------------------------------
  // per bit: meta flop, stable flop, history flop
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_bit
      logic meta_r;
      logic sync_r;
      logic hist_r;

      // only sync_r reads meta_r
      always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
          meta_r <= 1'b0;
          sync_r <= 1'b0;
          hist_r <= 1'b0;
        end else begin
          meta_r <= i_level[g];
          sync_r <= meta_r;
          hist_r <= sync_r;
        end
      end

      // one cycle pulse on a rising level
      assign o_pulse[g] = sync_r & ~hist_r;
    end
  endgenerate

endmodule

`default_nettype wire

// ===== hw/rcf_top.sv
// module: reset cause flags register with AHB-Lite slave and interrupt
//
// The implementer's own choices: the AHB-Lite slave port and the placing of the registers.
`default_nettype none

// Behaviour
// - flags tell which source reset the device
// - register is readable and writable by software
// - reset instruction clears software reset flag
// - power-up, clear-watchdog, sleep set watchdog flag
// - power-up/clear-watchdog set, sleep clears power-down flag
// - power-on reset clears power-on flag
// - brown-out reset clears brown-out flag
module rcf_top
  import rcf_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  input wire rcf_evt_s i_events,
  output logic [7:0] o_reset_cause,
  output logic o_interrupt_priority_enable,
  output logic o_irq
);

  // ----------------------------------------------------------------
  // event inputs
  // ----------------------------------------------------------------
  logic [RCF_EV_N-1:0] ev_pulse;
  rcf_evt_s ev;

  // event levels arrive from other domains; pulses come out aligned
  rcf_evt_sync #(
    .N(RCF_EV_N)
  ) u_evt_sync (
    .i_ref_clk(i_ref_clk),
    .i_reset(i_reset),
    .i_level(i_events),
    .o_pulse(ev_pulse)
  );

  assign ev = ev_pulse;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [RCF_RCC_W-1:0] rcc_r;
  logic [RCF_RCC_W-1:0] rcc_nxt;
  logic [RCF_EV_N-1:0] sts_r;
  logic [RCF_EV_N-1:0] sts_nxt;
  logic [RCF_EV_N-1:0] msk_r;
  logic [RCF_EV_N-1:0] msk_nxt;
  logic irq_r;
  rcf_aphase_s dph_r;
  rcf_aphase_s dph_nxt;
  rcf_bus_e bus_r;
  rcf_bus_e bus_nxt;
  logic hready_r;
  logic [31:0] hrdata_r;
  logic [31:0] hrdata_nxt;

  // ----------------------------------------------------------------
  // bus address phase and data phase decode
  // ----------------------------------------------------------------
  wire aph_take = i_hsel & i_htrans[RCF_HTRANS_ACT_BIT] & i_hready;
  wire aph_read = aph_take & ~i_hwrite;
  wire [RCF_ADDR_W-1:0] aph_off = i_haddr[RCF_ADDR_W-1:0];
  wire dph_wr = dph_r.valid & dph_r.write;
  wire dph_rd = dph_r.valid & ~dph_r.write;
  wire hit_rcc = dph_r.addr == RCF_RCC_OFF;
  wire hit_sts = dph_r.addr == RCF_STS_OFF;
  wire hit_msk = dph_r.addr == RCF_MSK_OFF;
  wire wr_rcc = dph_wr & hit_rcc;
  wire wr_sts = dph_wr & hit_sts;
  wire wr_msk = dph_wr & hit_msk;
  wire [RCF_RCC_W-1:0] wr_val = i_hwdata[RCF_RCC_W-1:0] & RCF_RCC_WMASK;
  wire [RCF_EV_N-1:0] wr_bits = i_hwdata[RCF_EV_N-1:0];
  wire rd_fire = dph_rd & (bus_r == RCF_BUS_RD_WAIT);

  // capture the address phase only while the bus is ready
  assign dph_nxt = i_hready ?
    rcf_aphase_s'{addr: aph_off, write: i_hwrite, valid: aph_take} :
    dph_r;

  // reads take one wait state so a write just before is seen
  always_comb begin
    case (bus_r)
      RCF_BUS_IDLE: begin
        bus_nxt = aph_read ? RCF_BUS_RD_WAIT : RCF_BUS_IDLE;
      end
      RCF_BUS_RD_WAIT: begin
        bus_nxt = rd_fire ? RCF_BUS_IDLE : RCF_BUS_RD_WAIT;
      end
      default: begin
        bus_nxt = RCF_BUS_IDLE;
      end
    endcase
  end

  // read data mux, unmapped offsets read as zero
  assign hrdata_nxt =
    ~rd_fire ? hrdata_r :
    hit_rcc ? {24'h00_0000, rcc_r} :
    hit_sts ? {26'h000_0000, sts_r} :
    hit_msk ? {26'h000_0000, msk_r} :
    RCF_RDATA_ZERO;

  // ----------------------------------------------------------------
  // reset cause flags next value
  // ----------------------------------------------------------------
  // software write first, hardware events then override it
  always_comb begin
    rcc_nxt = wr_rcc ? wr_val : rcc_r;
    if (ev.power_on) begin
      rcc_nxt[RCF_SWRST_BIT] = 1'b1;
      rcc_nxt[RCF_WDOG_BIT] = 1'b1;
      rcc_nxt[RCF_PWRDN_BIT] = 1'b1;
      rcc_nxt[RCF_PWRON_BIT] = 1'b0;
    end
    if (ev.clear_watchdog) begin
      rcc_nxt[RCF_WDOG_BIT] = 1'b1;
      rcc_nxt[RCF_PWRDN_BIT] = 1'b1;
    end
    if (ev.sleep) begin
      rcc_nxt[RCF_WDOG_BIT] = 1'b1;
      rcc_nxt[RCF_PWRDN_BIT] = 1'b0;
    end
    if (ev.wdt_timeout) begin
      rcc_nxt[RCF_WDOG_BIT] = 1'b0;
    end
    if (ev.sw_reset) begin
      rcc_nxt[RCF_SWRST_BIT] = 1'b0;
    end
    if (ev.brown_out) begin
      rcc_nxt[RCF_BROWN_BIT] = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // interrupt status and mask
  // ----------------------------------------------------------------
  // write one clears; an event in the same cycle wins
  assign sts_nxt = (sts_r & ~(wr_sts ? wr_bits : RCF_EV_NONE)) | ev_pulse;
  assign msk_nxt = wr_msk ? wr_bits : msk_r;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // flags hold the cause across device resets; i_reset is a full reset
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      rcc_r <= RCF_RCC_RESET;
      sts_r <= RCF_EV_NONE;
      msk_r <= RCF_EV_NONE;
      irq_r <= 1'b0;
    end else begin
      rcc_r <= rcc_nxt;
      sts_r <= sts_nxt;
      msk_r <= msk_nxt;
      irq_r <= |(sts_nxt & msk_nxt);
    end
  end

  // bus slave state
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      dph_r <= '0;
      bus_r <= RCF_BUS_IDLE;
      hready_r <= 1'b1;
      hrdata_r <= RCF_RDATA_ZERO;
    end else begin
      dph_r <= dph_nxt;
      bus_r <= bus_nxt;
      hready_r <= bus_nxt == RCF_BUS_IDLE;
      hrdata_r <= hrdata_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign o_hrdata = hrdata_r;
  assign o_hreadyout = hready_r;
  assign o_hresp = RCF_HRESP_OKAY;
  assign o_reset_cause = rcc_r;
  assign o_interrupt_priority_enable = rcc_r[RCF_PRIO_BIT];
  assign o_irq = irq_r;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_reset);

  // read request, one wait cycle, then ready with data
  sequence rd_req_s;
    aph_read;
  endsequence

  sequence rd_answer_s;
    !o_hreadyout ##1 o_hreadyout;
  endsequence

  read_wait_a: assert property (
    rd_req_s |=> rd_answer_s
  ) else $error("read did not answer after one wait state");

  read_data_a: assert property (
    (aph_read && i_haddr[RCF_ADDR_W-1:0] == RCF_RCC_OFF
      && ev_pulse == RCF_EV_NONE)
    |=> ##1 o_hrdata[RCF_RCC_W-1:0] == $past(rcc_r)
  ) else $error("read data does not show the flags");

  write_store_a: assert property (
    (wr_rcc && ev_pulse == RCF_EV_NONE) |=> rcc_r == $past(wr_val)
  ) else $error("flag register write not stored");

  swrst_clear_a: assert property (
    ev.sw_reset |=> !rcc_r[RCF_SWRST_BIT]
  ) else $error("software reset flag not cleared");

  wdog_set_a: assert property (
    ((ev.clear_watchdog || ev.sleep || ev.power_on) && !ev.wdt_timeout)
    |=> rcc_r[RCF_WDOG_BIT]
  ) else $error("watchdog flag not set");

  wdog_clear_a: assert property (
    ev.wdt_timeout |=> !rcc_r[RCF_WDOG_BIT]
  ) else $error("watchdog flag not cleared on time-out");

  pwrdn_sleep_a: assert property (
    ev.sleep |=> !rcc_r[RCF_PWRDN_BIT]
  ) else $error("power-down flag not cleared by sleep");

  pwrdn_set_a: assert property (
    ((ev.clear_watchdog || ev.power_on) && !ev.sleep)
    |=> rcc_r[RCF_PWRDN_BIT]
  ) else $error("power-down flag not set");

  pwron_clear_a: assert property (
    ev.power_on |=> !rcc_r[RCF_PWRON_BIT]
  ) else $error("power-on flag not cleared");

  brown_clear_a: assert property (
    ev.brown_out |=> !rcc_r[RCF_BROWN_BIT]
  ) else $error("brown-out flag not cleared");

  brown_only_sw_a: assert property (
    $rose(rcc_r[RCF_BROWN_BIT]) |-> $past(wr_rcc)
  ) else $error("brown-out flag set without a software write");

  prio_follow_a: assert property (
    (wr_rcc && ev_pulse == RCF_EV_NONE)
    |=> o_interrupt_priority_enable == $past(i_hwdata[RCF_PRIO_BIT])
  ) else $error("priority enable does not follow the write");

  irq_level_a: assert property (
    ##1 o_irq == |(sts_r & msk_r)
  ) else $error("interrupt output does not match status and mask");

  sticky_set_a: assert property (
    ev_pulse != RCF_EV_NONE |=> (sts_r & $past(ev_pulse)) == $past(ev_pulse)
  ) else $error("event did not set its status bit");

  // status bits stay put unless an event or a clear arrives
  sts_hold_a: assert property (
    (!wr_sts && ev_pulse == RCF_EV_NONE) |=> $stable(sts_r)
  ) else $error("status changed without a cause");

  // writing ones clears exactly those status bits
  sts_clear_a: assert property (
    (wr_sts && ev_pulse == RCF_EV_NONE)
    |=> sts_r == ($past(sts_r) & ~$past(wr_bits))
  ) else $error("status write did not clear the chosen bits");

  // the mask takes the written value
  msk_store_a: assert property (
    wr_msk |=> msk_r == $past(wr_bits)
  ) else $error("mask write not stored");

  // an unmasked event raises the interrupt at once
  irq_event_a: assert property (
    ((ev_pulse & msk_r) != RCF_EV_NONE && !wr_msk) |=> o_irq
  ) else $error("unmasked event did not raise the interrupt");

  // ----------------------------------------------------------------
  // flag and bus checks
  // ----------------------------------------------------------------
  // flags keep the recorded cause until something changes them
  flags_hold_a: assert property (
    (!wr_rcc && ev_pulse == RCF_EV_NONE) |=> $stable(rcc_r)
  ) else $error("flags changed without a cause");

  // power-on brings the software reset flag back to one
  pwron_swrst_a: assert property (
    (ev.power_on && !ev.sw_reset) |=> rcc_r[RCF_SWRST_BIT]
  ) else $error("power-on did not set the software reset flag");

  // unimplemented bits of the flag register stay zero
  unimpl_zero_a: assert property (
    (o_reset_cause & ~RCF_RCC_WMASK) == '0
  ) else $error("unimplemented flag bits are not zero");

  // a write never inserts a wait state
  write_zero_wait_a: assert property (
    (aph_take && i_hwrite) |=> o_hreadyout
  ) else $error("write inserted a wait state");

  // only a read takes the bus out of its ready state
  ready_idle_a: assert property (
    (!aph_read && o_hreadyout) |=> o_hreadyout
  ) else $error("wait state without a read");

  // read data stands until the next read completes
  read_hold_a: assert property (
    !rd_fire |=> $stable(o_hrdata)
  ) else $error("read data changed outside a read");

  // status and mask reads show the registers
  read_sts_a: assert property (
    (aph_read && aph_off == RCF_STS_OFF)
    |=> ##1 o_hrdata[RCF_EV_N-1:0] == $past(sts_r)
  ) else $error("status read data wrong");

  read_msk_a: assert property (
    (aph_read && aph_off == RCF_MSK_OFF)
    |=> ##1 o_hrdata[RCF_EV_N-1:0] == $past(msk_r)
  ) else $error("mask read data wrong");

  // offsets outside the map read as zero
  unmapped_zero_a: assert property (
    (aph_read && aph_off != RCF_RCC_OFF && aph_off != RCF_STS_OFF
      && aph_off != RCF_MSK_OFF)
    |=> ##1 o_hrdata == RCF_RDATA_ZERO
  ) else $error("unmapped read did not return zero");

endmodule

`default_nettype wire

// ===== testbench/rcf_top_tb.sv
// testbench: register bus, event and interrupt checks of the reset cause block
`default_nettype none

module rcf_top_tb
  import rcf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // stimulus and observation signals
  // ----------------------------------------------------------------
  logic clk;
  logic rst;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [31:0] hwdata;
  logic [5:0] ev_v;
  wire logic hready;
  wire logic [31:0] hrdata;
  wire logic hresp;
  wire logic [7:0] rcause;
  wire logic prio;
  wire logic irq;
  logic rdy_n;
  logic [31:0] rd_n;
  logic [7:0] rc_n;
  logic irq_n;
  logic prio_n;
  int errors;
  int compares;

  rcf_top rcf_top_i (
    .i_ref_clk(clk),
    .i_reset(rst),
    .i_hsel(hsel),
    .i_haddr(haddr),
    .i_htrans(htrans),
    .i_hwrite(hwrite),
    .i_hsize(3'h2),
    .i_hwdata(hwdata),
    .i_hready(hready),
    .o_hrdata(hrdata),
    .o_hreadyout(hready),
    .o_hresp(hresp),
    .i_events(rcf_evt_s'(ev_v)),
    .o_reset_cause(rcause),
    .o_interrupt_priority_enable(prio),
    .o_irq(irq)
  );

  // clock of 40 ns period
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // settled copies of the outputs, taken away from the rising edge
  always @(negedge clk) begin
    rdy_n = hready;
    rd_n = hrdata;
    rc_n = rcause;
    irq_n = irq;
    prio_n = prio;
  end

  // ----------------------------------------------------------------
  // helper tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one single word transfer; entered and left right after a rising edge
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= w;
    // address phase stands until hready is sampled high
    do begin
      @(posedge clk);
    end while (rdy_n !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    // data phase ends at the edge that samples hready high
    do begin
      @(posedge clk);
    end while (rdy_n !== 1'b1);
    r = rd_n;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    bus(1'b1, a, d, dummy);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, a, 32'h0000_0000, r);
    chk(r, exp);
  endtask

  // one event edge, then check the flags after the sync delay has passed
  task automatic event_chk(input int b, input logic [7:0] exp);
    ev_v <= 6'h01 << b;
    repeat (6) @(posedge clk);
    ev_v <= 6'h00;
    repeat (3) @(posedge clk);
    chk({24'h00_0000, rc_n}, {24'h00_0000, exp});
  endtask

  task automatic summarize();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // watchdog against a hung bus or event wait
  // ----------------------------------------------------------------
  initial begin
    #(40 * 4000);
    errors++;
    summarize();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    errors = 0;
    compares = 0;
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0000_0000;
    ev_v = 6'h00;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // reset values and plain access
    rd_chk(RCF_RCC_OFF, 32'h0000_001c);
    chk({31'h0000_0000, prio_n}, 32'h0000_0000);
    chk({31'h0000_0000, hresp}, 32'h0000_0000);
    wr(RCF_RCC_OFF, 32'h0000_00ff);
    rd_chk(RCF_RCC_OFF, 32'h0000_009f);
    chk({31'h0000_0000, prio_n}, 32'h0000_0001);
    // each event source in turn, priority enable kept high
    event_chk(0, 8'h8f);
    event_chk(1, 8'h87);
    event_chk(2, 8'h8f);
    event_chk(3, 8'h8b);
    event_chk(5, 8'h8a);
    event_chk(4, 8'h9c);
    rd_chk(RCF_RCC_OFF, 32'h0000_009c);
    chk({31'h0000_0000, prio_n}, 32'h0000_0001);
    // software re-arms the power-on and brown-out flags
    wr(RCF_RCC_OFF, 32'h0000_0003);
    rd_chk(RCF_RCC_OFF, 32'h0000_0003);
    chk({31'h0000_0000, prio_n}, 32'h0000_0000);
    // status collected every event, no mask means no interrupt
    rd_chk(RCF_STS_OFF, 32'h0000_003f);
    chk({31'h0000_0000, irq_n}, 32'h0000_0000);
    wr(RCF_MSK_OFF, 32'h0000_0008);
    rd_chk(RCF_MSK_OFF, 32'h0000_0008);
    chk({31'h0000_0000, irq_n}, 32'h0000_0001);
    wr(RCF_STS_OFF, 32'h0000_0008);
    rd_chk(RCF_STS_OFF, 32'h0000_0037);
    chk({31'h0000_0000, irq_n}, 32'h0000_0000);
    wr(RCF_MSK_OFF, 32'h0000_003f);
    rd_chk(RCF_STS_OFF, 32'h0000_0037);
    chk({31'h0000_0000, irq_n}, 32'h0000_0001);
    wr(RCF_STS_OFF, 32'h0000_003f);
    rd_chk(RCF_STS_OFF, 32'h0000_0000);
    chk({31'h0000_0000, irq_n}, 32'h0000_0000);
    // an unmasked event raises the interrupt
    event_chk(3, 8'h0b);
    chk({31'h0000_0000, irq_n}, 32'h0000_0001);
    rd_chk(RCF_STS_OFF, 32'h0000_0008);
    // unmapped offset reads zero and ignores writes
    wr(8'h0c, 32'h0000_00ff);
    rd_chk(8'h0c, 32'h0000_0000);
    rd_chk(RCF_RCC_OFF, 32'h0000_000b);
    // mid-run reset restores every register
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd_chk(RCF_RCC_OFF, 32'h0000_001c);
    rd_chk(RCF_STS_OFF, 32'h0000_0000);
    rd_chk(RCF_MSK_OFF, 32'h0000_0000);
    chk({31'h0000_0000, prio_n}, 32'h0000_0000);
    chk({31'h0000_0000, irq_n}, 32'h0000_0000);
    summarize();
  end

endmodule

`default_nettype wire
